/* bcs_boot_config.sv */
// Boot configuration loader: bus setup bytes and signature verify port
`timescale 1ns/10ps

module bcs_boot_config #(
   parameter logic [7:0] SIG_MAKER_CODE   = 8'h5a, // Arbitrary value
   parameter logic [7:0] SIG_FAMILY_CODE  = 8'h3c, // Arbitrary value
   parameter logic [7:0] SIG_VARIANT_CODE = 8'h11  // Arbitrary value
) (
   input  wire logic                clock,
   input  wire logic                reset_n,
   input  wire logic                has_onchip_code,
   input  wire logic [7:0]          onchip_cfg_byte_zero,
   input  wire logic [7:0]          onchip_cfg_byte_one,
   output logic                     ext_fetch_req,
   output logic [15:0]              ext_fetch_addr,
   input  wire logic                ext_fetch_ack,
   input  wire logic [7:0]          ext_fetch_data,
   output logic                     cfg_valid,
   output bcs_pkg::bcs_bus_cfg_t    bus_cfg,
   output logic [7:0]               bus_config_byte_zero,
   output logic [7:0]               bus_config_byte_one,
   input  wire logic [7:0]          program_strobe_n_port0_in,
   input  wire logic [7:0]          program_strobe_n_port1_in,
   input  wire logic [7:0]          program_strobe_n_port3_in,
   input  wire logic                program_strobe_n,
   output logic [7:0]               program_strobe_n_port2_out,
   output logic                     program_strobe_n_port2_oe
);

   // Signature bytes sit in the arbitrary identity parameters above

   // =========================================================
   // Decode helpers
   // Active-low wait field to count of inserted wait states
   function automatic logic [1:0] wait_count(input logic [1:0] field_n);
      wait_count = ~field_n;
   endfunction : wait_count

   // Byte pair to bus settings
   function automatic bcs_pkg::bcs_bus_cfg_t decode_cfg(
      input logic [7:0] byte_zero,
      input logic [7:0] byte_one);
      bcs_pkg::bcs_bus_cfg_t c;
      c.code_wait  = wait_count({byte_zero[bcs_pkg::CODE_WAIT_HI_BIT],
                              byte_zero[bcs_pkg::CODE_WAIT_LO_BIT]});
      c.data_wait  = wait_count({byte_one[bcs_pkg::DATA_WAIT_HI_BIT],
                              byte_one[bcs_pkg::DATA_WAIT_LO_BIT]});
      c.ale_extend = ~byte_zero[bcs_pkg::LATCH_EXTEND_BIT];
      c.page_mode  = ~byte_zero[bcs_pkg::PAGE_SELECT_BIT];
      decode_cfg   = c;
   endfunction : decode_cfg

   // =========================================================
   // Loader state
   bcs_pkg::bcs_state_t state_reg;
   bcs_pkg::bcs_state_t state_next;
   logic [7:0]          byte_zero_reg;
   logic [7:0]          byte_one_reg;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         bcs_pkg::BCS_ST_STRAP: begin
            if (has_onchip_code) begin
               state_next = bcs_pkg::BCS_ST_APPLY;
            end else begin
               state_next = bcs_pkg::BCS_ST_FETCH0;
            end
         end
         bcs_pkg::BCS_ST_FETCH0: begin
            if (ext_fetch_ack) begin
               state_next = bcs_pkg::BCS_ST_FETCH1;
            end
         end
         bcs_pkg::BCS_ST_FETCH1: begin
            if (ext_fetch_ack) begin
               state_next = bcs_pkg::BCS_ST_APPLY;
            end
         end
         bcs_pkg::BCS_ST_APPLY: begin
            state_next = bcs_pkg::BCS_ST_DONE;
         end
         bcs_pkg::BCS_ST_DONE: begin
            state_next = bcs_pkg::BCS_ST_DONE;
         end
         default: begin
            state_next = bcs_pkg::BCS_ST_STRAP;
         end
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= bcs_pkg::BCS_ST_STRAP;
      end else begin
         state_reg <= state_next;
      end
   end

   // =========================================================
   // Configuration byte capture
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         byte_zero_reg <= bcs_pkg::CFG_BYTE_RESET;
         byte_one_reg  <= bcs_pkg::CFG_BYTE_RESET;
      end else begin
         case (state_reg)
            bcs_pkg::BCS_ST_STRAP: begin
               if (has_onchip_code) begin
                  byte_zero_reg <= onchip_cfg_byte_zero;
                  byte_one_reg  <= onchip_cfg_byte_one;
               end
            end
            bcs_pkg::BCS_ST_FETCH0: begin
               if (ext_fetch_ack) begin
                  byte_zero_reg <= ext_fetch_data;
               end
            end
            bcs_pkg::BCS_ST_FETCH1: begin
               if (ext_fetch_ack) begin
                  byte_one_reg <= ext_fetch_data;
               end
            end
            default: begin
               byte_zero_reg <= byte_zero_reg;
               byte_one_reg  <= byte_one_reg;
            end
         endcase
      end
   end

   // External fetch request, held until acknowledged
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ext_fetch_req  <= 1'b0;
         ext_fetch_addr <= bcs_pkg::CFG_BYTE_ZERO_ADDR;
      end else begin
         case (state_next)
            bcs_pkg::BCS_ST_FETCH0: begin
               ext_fetch_req  <= 1'b1;
               ext_fetch_addr <= bcs_pkg::CFG_BYTE_ZERO_ADDR;
            end
            bcs_pkg::BCS_ST_FETCH1: begin
               ext_fetch_req  <= 1'b1;
               ext_fetch_addr <= bcs_pkg::CFG_BYTE_ONE_ADDR;
            end
            default: begin
               ext_fetch_req  <= 1'b0;
               ext_fetch_addr <= ext_fetch_addr;
            end
         endcase
      end
   end

   // =========================================================
   // Bus settings, applied once before the first bus cycle
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cfg_valid            <= 1'b0;
         bus_cfg              <= decode_cfg(bcs_pkg::CFG_BYTE_RESET,
                                            bcs_pkg::CFG_BYTE_RESET);
         bus_config_byte_zero <= bcs_pkg::CFG_BYTE_RESET;
         bus_config_byte_one  <= bcs_pkg::CFG_BYTE_RESET;
      end else if (state_reg == bcs_pkg::BCS_ST_APPLY) begin
         cfg_valid            <= 1'b1;
         bus_cfg              <= decode_cfg(byte_zero_reg, byte_one_reg);
         bus_config_byte_zero <= byte_zero_reg;
         bus_config_byte_one  <= byte_one_reg;
      end
   end

   // =========================================================
   // Signature verify port
   bcs_pkg::bcs_program_strobe_n_pins_t pins_raw;
   bcs_pkg::bcs_program_strobe_n_pins_t pins_sync;
   logic                    verify_sel;

   assign pins_raw = '{mode:             program_strobe_n_port0_in,
                       addr:             {program_strobe_n_port1_in, program_strobe_n_port3_in},
                       program_strobe_n: program_strobe_n};

   bcs_sync #(
      .WIDTH       ($bits(bcs_pkg::bcs_program_strobe_n_pins_t)),
      .RESET_VALUE ({8'h00, 16'h0000, 1'b1})
   ) u_pin_sync (
      .clock    (clock),
      .reset_n  (reset_n),
      .async_in (pins_raw),
      .sync_out (pins_sync)
   );

   assign verify_sel = (pins_sync.mode == bcs_pkg::MODE_VERIFY_SIG)
                       && pins_sync.program_strobe_n;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         program_strobe_n_port2_out <= bcs_pkg::SIG_UNMAPPED_DATA;
         program_strobe_n_port2_oe  <= 1'b0;
      end else begin
         program_strobe_n_port2_oe <= verify_sel;
         case (pins_sync.addr)
            bcs_pkg::SIG_MAKER_ADDR:   program_strobe_n_port2_out <= SIG_MAKER_CODE;
            bcs_pkg::SIG_FAMILY_ADDR:  program_strobe_n_port2_out <= SIG_FAMILY_CODE;
            bcs_pkg::SIG_VARIANT_ADDR: program_strobe_n_port2_out <= SIG_VARIANT_CODE;
            default: program_strobe_n_port2_out <= bcs_pkg::SIG_UNMAPPED_DATA;
         endcase
      end
   end

endmodule : bcs_boot_config

/* bcs_boot_config_assertions.sv */
// Checker watching the boot configuration loader ports
`timescale 1ns/10ps
module bcs_boot_config_assertions (
   input wire logic                  clock,
   input wire logic                  reset_n,
   input wire logic                  ext_fetch_req,
   input wire logic [15:0]           ext_fetch_addr,
   input wire logic                  ext_fetch_ack,
   input wire logic                  cfg_valid,
   input wire bcs_pkg::bcs_bus_cfg_t bus_cfg,
   input wire logic [7:0]            bus_config_byte_zero,
   input wire logic [7:0]            bus_config_byte_one,
   input wire logic [7:0]            program_strobe_n_port0_in,
   input wire logic                  program_strobe_n,
   input wire logic                  program_strobe_n_port2_oe
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   a_code_wait_map: assert property (cfg_valid |->
      bus_cfg.code_wait == ~bus_config_byte_zero[6:5]) else $error("code wait");
   a_data_wait_map: assert property (cfg_valid |->
      bus_cfg.data_wait == ~bus_config_byte_one[2:1]) else $error("data wait");
   a_latch_ext_map: assert property (cfg_valid |->
      bus_cfg.ale_extend == ~bus_config_byte_zero[4]) else $error("latch");
   a_page_mode_map: assert property (cfg_valid |->
      bus_cfg.page_mode == ~bus_config_byte_zero[1]) else $error("page mode");
   a_settings_held: assert property (cfg_valid && $past(cfg_valid) |->
      $stable({bus_cfg, bus_config_byte_zero, bus_config_byte_one}))
      else $error("settings changed after load");
   a_fetch_second: assert property (ext_fetch_req && ext_fetch_ack &&
      ext_fetch_addr == bcs_pkg::CFG_BYTE_ZERO_ADDR |=> ext_fetch_req &&
      ext_fetch_addr == bcs_pkg::CFG_BYTE_ONE_ADDR)
      else $error("second fetch");
   a_apply_delay: assert property (ext_fetch_req && ext_fetch_ack &&
      ext_fetch_addr == bcs_pkg::CFG_BYTE_ONE_ADDR |=>
      !ext_fetch_req && !cfg_valid ##1 cfg_valid)
      else $error("apply timing");
   a_verify_enable: assert property (program_strobe_n_port2_oe ==
      ($past(program_strobe_n_port0_in, 3) == bcs_pkg::MODE_VERIFY_SIG &&
      $past(program_strobe_n, 3))) else $error("port 2 enable");
   c_loaded: cover property ($rose(cfg_valid));
   c_second_ack: cover property (ext_fetch_ack && ext_fetch_addr[0]);
   c_verify: cover property (program_strobe_n_port2_oe);
endmodule : bcs_boot_config_assertions

bind bcs_boot_config bcs_boot_config_assertions chk (.clock(clock),
   .reset_n(reset_n), .ext_fetch_req(ext_fetch_req),
   .ext_fetch_addr(ext_fetch_addr), .ext_fetch_ack(ext_fetch_ack),
   .cfg_valid(cfg_valid), .bus_cfg(bus_cfg),
   .bus_config_byte_zero(bus_config_byte_zero),
   .bus_config_byte_one(bus_config_byte_one),
   .program_strobe_n_port0_in(program_strobe_n_port0_in), .program_strobe_n(program_strobe_n),
   .program_strobe_n_port2_oe(program_strobe_n_port2_oe));

/* bcs_ext_mem.sv */
// External memory model holding the two configuration bytes
`timescale 1ns/10ps
module bcs_ext_mem (
   input  wire logic        clock,
   input  wire logic        fetch_req,
   input  wire logic [15:0] fetch_addr,
   input  wire logic [7:0]  byte_zero,
   input  wire logic [7:0]  byte_one,
   input  wire logic [3:0]  delay,
   output logic             fetch_ack = 1'b0,
   output logic [7:0]       fetch_data = 8'h00
);
   logic [3:0] wait_cnt = 4'h0;
   // Answers after delay cycles; data toggles outside an answer
   always @(negedge clock) begin
      fetch_data <= ~fetch_data;
      wait_cnt   <= wait_cnt + 4'h1;
      if (fetch_ack || !fetch_req) begin
         fetch_ack <= 1'b0;
         wait_cnt  <= 4'h0;
      end else if (wait_cnt >= delay) begin
         fetch_ack  <= 1'b1;
         fetch_data <= (fetch_addr == bcs_pkg::CFG_BYTE_ZERO_ADDR) ?
            byte_zero : byte_one;
      end
   end
endmodule : bcs_ext_mem

/* bcs_pkg.sv */
// Constants, types and field layout of the boot configuration loader
package bcs_pkg;

   // =========================================================
   // Configuration byte addresses in external memory
   localparam logic [15:0] CFG_BYTE_ZERO_ADDR = 16'hfff8;
   localparam logic [15:0] CFG_BYTE_ONE_ADDR  = 16'hfff9;

   // =========================================================
   // Field positions, byte zero
   localparam int CODE_WAIT_HI_BIT  = 6;
   localparam int CODE_WAIT_LO_BIT  = 5;
   localparam int LATCH_EXTEND_BIT  = 4;
   localparam int PAGE_SELECT_BIT   = 1;

   // Field positions, byte one
   localparam int DATA_WAIT_HI_BIT  = 2;
   localparam int DATA_WAIT_LO_BIT  = 1;
   localparam int RSVD_ONE_HI_BIT   = 7;
   localparam int RSVD_ONE_LO_BIT   = 5;

   // Reset value of the configuration byte registers (erased state)
   localparam logic [7:0] CFG_BYTE_RESET = 8'hff;

   // =========================================================
   // Programming and verification
   localparam logic [7:0]  MODE_VERIFY_SIG   = 8'h29;
   localparam logic [15:0] SIG_MAKER_ADDR    = 16'h0030;
   localparam logic [15:0] SIG_FAMILY_ADDR   = 16'h0031;
   localparam logic [15:0] SIG_VARIANT_ADDR  = 16'h0060;
   localparam logic [7:0]  SIG_UNMAPPED_DATA = 8'hff;

   // =========================================================
   // Loader states
   typedef enum logic [2:0] {
      BCS_ST_STRAP = 3'b000,
      BCS_ST_FETCH0 = 3'b001,
      BCS_ST_FETCH1 = 3'b010,
      BCS_ST_APPLY = 3'b011,
      BCS_ST_DONE  = 3'b100
   } bcs_state_t;

   // Decoded external bus settings
   typedef struct packed {
      logic [1:0] code_wait;
      logic [1:0] data_wait;
      logic       ale_extend;
      logic       page_mode;
   } bcs_bus_cfg_t;

   // Programming pins as seen after synchronisation
   typedef struct packed {
      logic [7:0]  mode;
      logic [15:0] addr;
      logic        program_strobe_n;
   } bcs_program_strobe_n_pins_t;

endpackage : bcs_pkg

/* bcs_sync.sv */
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/10ps
module bcs_sync #(
   parameter int           WIDTH      = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one_reg;

   // =========================================================
   // Synchronising flops
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stage_one_reg <= RESET_VALUE;
         sync_out      <= RESET_VALUE;
      end else begin
         stage_one_reg <= async_in;
         sync_out      <= stage_one_reg;
      end
   end

endmodule : bcs_sync

/* testbench.sv */
// Self-checking bench for the boot configuration loader
`timescale 1ns/10ps
module testbench;
   // Identity values are arbitrary
   localparam logic [7:0] MAKER = 8'h5a, FAMILY = 8'h3c, VARIANT = 8'h11;
   localparam logic [7:0] VFY = bcs_pkg::MODE_VERIFY_SIG;
   logic                  clock, reset_n, strap, strobe_n, ack, req, valid, oe;
   logic [7:0]            ob0, ob1, mb0, mb1, fdata, p0, p1, p3, p2, cb0, cb1;
   logic [15:0]           faddr;
   logic [3:0]            dly;
   bcs_pkg::bcs_bus_cfg_t cfg;
   int                    fail_count = 0;
   int                    tests_run = 0;
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   bcs_boot_config #(.SIG_MAKER_CODE(MAKER), .SIG_FAMILY_CODE(FAMILY),
      .SIG_VARIANT_CODE(VARIANT)) uut (.clock(clock), .reset_n(reset_n),
      .has_onchip_code(strap), .onchip_cfg_byte_zero(ob0),
      .onchip_cfg_byte_one(ob1), .ext_fetch_req(req), .ext_fetch_addr(faddr),
      .ext_fetch_ack(ack), .ext_fetch_data(fdata), .cfg_valid(valid),
      .bus_cfg(cfg), .bus_config_byte_zero(cb0), .bus_config_byte_one(cb1),
      .program_strobe_n_port0_in(p0), .program_strobe_n_port1_in(p1), .program_strobe_n_port3_in(p3),
      .program_strobe_n(strobe_n), .program_strobe_n_port2_out(p2), .program_strobe_n_port2_oe(oe));
   bcs_ext_mem mem (.clock(clock), .fetch_req(req), .fetch_addr(faddr),
      .byte_zero(mb0), .byte_one(mb1), .delay(dly), .fetch_ack(ack),
      .fetch_data(fdata));
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_byte
   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop
   // Odd i loads from external memory, i of 3 from a slow one
   task automatic boot(input logic [1:0] i);
      logic [7:0] z, o;
      int         n;
      z = {1'b1, i, i[0], 2'b11, i[1], 1'b1};
      o = {5'h1f, ~i, 1'b1};
      strap = ~i[0];
      {ob0, ob1} = i[0] ? ~{z, o} : {z, o};
      {mb0, mb1} = i[0] ? {z, o} : ~{z, o};
      dly = i[1] ? 4'h3 : 4'h0;
      reset_n = 1'b0;
      repeat (12) @(negedge clock);
      check_byte({7'h00, valid}, 8'h00);
      check_byte(cb0, bcs_pkg::CFG_BYTE_RESET);
      reset_n = 1'b1;
      for (n = 0; n < 40 && valid !== 1'b1; n++)
         @(negedge clock);
      check_byte({7'h00, valid}, 8'h01);
      check_byte({2'b00, cfg},
         {2'b00, ~i, i, ~i[0], ~i[1]});
      check_byte(cb0, z);
      check_byte(cb1, o);
      strap = i[0];
      {ob0, ob1, mb0, mb1} = 32'h0;
      repeat (4) @(negedge clock);
      check_byte({2'b00, cfg}, {2'b00, ~i, i, ~i[0], ~i[1]});
      $display("boot test %0d done", i);
   endtask : boot
   task automatic sig(input logic [7:0] m, input logic [15:0] a,
      input logic s, input logic e, input logic [7:0] d);
      p0 = m;
      {p1, p3} = a;
      strobe_n = s;
      repeat (4) @(negedge clock);
      check_byte({7'h00, oe}, {7'h00, e});
      if (e)
         check_byte(p2, d);
   endtask : sig
   initial begin
      {reset_n, strap, strobe_n} = 3'b011;
      {ob0, ob1, mb0, mb1, p0, p1, p3} = '0;
      dly = 4'h0;
      for (int i = 0; i < 4; i++)
         boot(i[1:0]);
      sig(VFY, bcs_pkg::SIG_MAKER_ADDR, 1'b1, 1'b1, MAKER);
      sig(VFY, bcs_pkg::SIG_FAMILY_ADDR, 1'b1, 1'b1, FAMILY);
      sig(VFY, bcs_pkg::SIG_VARIANT_ADDR, 1'b1, 1'b1, VARIANT);
      sig(VFY, 16'h0061, 1'b1, 1'b1, bcs_pkg::SIG_UNMAPPED_DATA);
      sig(8'h28, bcs_pkg::SIG_MAKER_ADDR, 1'b1, 1'b0, 8'h00);
      sig(VFY, bcs_pkg::SIG_MAKER_ADDR, 1'b0, 1'b0, 8'h00);
      // Strobe low for 100 us in all, then high again
      repeat (12496) @(negedge clock);
      sig(VFY, bcs_pkg::SIG_FAMILY_ADDR, 1'b1, 1'b1, FAMILY);
      $display("signature test done");
      report_and_stop();
   end
   initial begin
      repeat (30000) @(posedge clock);
      fail_count++;
      report_and_stop();
   end
endmodule : testbench
